// *** src/sfa_align_top.sv ***
//
// Contract
// - readback subtracts 3 in mode zero, else 1
// - readback is 5 bits, upper three read zero
// - writing one over zero triggers one realignment
// - reference bank 0 if in use, else bank 2
// - never realign to receiver unless software asks
// - changed strobe alignment raises realigned alarm
// - strobe alignment takes receiver phase at once
// - strobe requests ignored after reference sync
// - enable set realigns on every reference edge
// - misaligned edge while enabled raises alarm, realigns
// - enable clear leaves alignment unchanged
// - misaligned edges always raise misalignment alarm
// - edge beside enabling write may still align
// - readback estimates latency setting from arrival
//
`timescale 1ns/1ns
`default_nettype none

`include "sfa_defs.svh"

module sfa_align_top #(
    parameter int PHASE_W = 3,
    parameter int LAT_W   = 5,
    parameter int MODE_W  = 2
) (
    // converter clock, reset, enable
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_ce,
    // register port
    input  wire logic [11:0]        i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output var  logic [7:0]         o_rdata,
    // alarm clears from the alarm register
    input  wire logic               i_clr_realigned,
    input  wire logic               i_clr_misalign,
    // device configuration and datapath status
    input  wire logic               i_datapath_enable,
    input  wire logic [MODE_W-1:0]  i_interface_mode,
    input  wire logic               i_bank0_in_use,
    input  wire logic               i_first_sample,
    // reference pin
    input  wire logic               i_sysref,
    // link side
    input  wire logic               i_lvds_clk,
    input  wire logic               i_strobe_bank0,
    input  wire logic               i_strobe_bank2,
    // status
    output var  logic               o_realigned_alarm,
    output var  logic               o_misalign_alarm,
    output var  logic               o_refedge_align_enable,
    output var  logic               o_ref_synced,
    output var  logic               o_strobe_busy,
    output var  logic [PHASE_W-1:0] o_read_phase,
    output var  logic [PHASE_W-1:0] o_align_offset
);

    localparam int ALIGN_RSV_W = `SFA_ALIGN_RSV_MSB - `SFA_ALIGN_RSV_LSB + 1;

    typedef struct packed {
        sfa_pkg::sfa_state_t  st;
        logic                 strobe_busy;
        logic                 refedge_align_enable;
        logic                 strobe_bit;
        logic [ALIGN_RSV_W-1:0] align_rsv;
        logic                 req_tgl;
        logic                 ack_seen;
        logic                 sref_prev;
        logic [PHASE_W-1:0]   read_phase;
        logic [PHASE_W-1:0]   align_offset;
        logic                 synced;
        logic                 realigned_alarm;
        logic                 misalign_alarm;
        logic [LAT_W-1:0]     lat_cnt;
        logic                 lat_run;
        logic [LAT_W-1:0]     lat_val;
        logic [7:0]           rdata;
    } sfa_top_state_t;

    sfa_top_state_t     cur;
    sfa_top_state_t     next_cur;
    logic               sref_sync;
    logic               ack_sync;
    logic [PHASE_W-1:0] link_phase;
    logic               align_wr;
    logic               eff_enable;
    logic               sref_edge;
    logic               set_realigned;
    logic               set_misalign;
    logic [LAT_W-1:0]   lat_sub;
    logic [LAT_W-1:0]   lat_arrive;
    logic [LAT_W-1:0]   lat_est;
    logic               link_ack_tgl;
    logic               mode_zero;
    logic               rd_align;
    logic               rd_lat3;
    logic [7:0]         align_word;
    logic [7:0]         lat3_word;
    logic               strobe_rise;
    logic               strobe_req;
    logic               ack_arrived;
    logic               offset_moved;
    logic               edge_misaligned;
    logic               edge_realigns;
    logic               dp_rearm;
    logic               lat_held;

    // reference pin into the converter domain
    sfa_sync2 #(
        .WIDTH (1)
    ) u_sref_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_sysref),
        .o_sync  (sref_sync)
    );

    // acknowledge toggle back from the link domain
    sfa_sync2 #(
        .WIDTH (1)
    ) u_ack_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (link_ack_tgl),
        .o_sync  (ack_sync)
    );

    sfa_link_capture #(
        .PHASE_W (PHASE_W)
    ) u_link (
        .i_lvds_clk     (i_lvds_clk),
        .i_rst_n        (i_rst_n),
        .i_strobe_bank0 (i_strobe_bank0),
        .i_strobe_bank2 (i_strobe_bank2),
        .i_use_bank0    (i_bank0_in_use),
        .i_req_tgl      (cur.req_tgl),
        .o_ack_tgl      (link_ack_tgl),
        .o_phase        (link_phase)
    );

    assign align_wr   = i_wr && (i_addr == `SFA_ALIGN_OFS);
    assign sref_edge  = sref_sync && !cur.sref_prev;
    // a write landing with the edge already counts
    assign eff_enable = align_wr ? i_wdata[`SFA_REFEDGE_EN_BIT]
                                 : cur.refedge_align_enable;

    // latency estimate: cycles from the detected edge, less the mode's
    // pipeline share, floored at zero; once the counter holds at its top the estimate wraps to zero
    assign mode_zero  = (i_interface_mode == '0);
    assign lat_sub    = mode_zero ? `SFA_LAT_SUB_MODE0
                                  : `SFA_LAT_SUB_OTHER;
    assign lat_arrive = LAT_W'(cur.lat_cnt + 1'b1);
    assign lat_est    = (lat_arrive > lat_sub) ? LAT_W'(lat_arrive - lat_sub)
                                               : '0;
    assign lat_held   = (cur.lat_cnt == '1);

    // register decode; the readback register has no write path
    assign rd_align   = i_rd && (i_addr == `SFA_ALIGN_OFS);
    assign rd_lat3    = i_rd && (i_addr == `SFA_LAT3_OFS);
    assign align_word = {cur.align_rsv, cur.strobe_bit, cur.refedge_align_enable};
    assign lat3_word  = {{`SFA_LAT_RSV_W{1'b0}}, cur.lat_val};

    // only a zero-to-one write asks for alignment, and only before the
    // reference sync; the link clock is unrelated, so nothing re-runs it
    assign strobe_rise = align_wr && i_wdata[`SFA_STROBE_BIT] && !cur.strobe_bit;
    assign strobe_req  = strobe_rise && !cur.synced;

    // the phase word is stable on the link side before its toggle arrives,
    // so it may be taken as soon as the synchronised toggle differs
    assign ack_arrived  = (ack_sync != cur.ack_seen);
    assign offset_moved = (link_phase != cur.align_offset);

    // reference edges are expected at read phase zero
    assign edge_misaligned = sref_edge && (cur.read_phase != '0);
    assign edge_realigns   = sref_edge && eff_enable;

    // datapath disable re-arms strobe alignment, unless an enabled edge
    // syncs in that very cycle
    assign dp_rearm = !i_datapath_enable && !edge_realigns;

    always_comb begin
        next_cur      = cur;
        set_realigned = 1'b0;
        set_misalign  = 1'b0;
        if (i_ce) begin
            next_cur.sref_prev  = sref_sync;
            next_cur.read_phase = PHASE_W'(cur.read_phase + 1'b1);

            // register writes
            if (align_wr) begin
                next_cur.refedge_align_enable = i_wdata[`SFA_REFEDGE_EN_BIT];
                next_cur.strobe_bit           = i_wdata[`SFA_STROBE_BIT];
                next_cur.align_rsv = i_wdata[`SFA_ALIGN_RSV_MSB:`SFA_ALIGN_RSV_LSB];
            end

            // one-shot strobe alignment, only on a zero-to-one write
            unique case (cur.st)
                sfa_pkg::SFA_ST_IDLE: begin
                    if (strobe_req) begin
                        next_cur.req_tgl     = ~cur.req_tgl;
                        next_cur.st          = sfa_pkg::SFA_ST_WAIT;
                        next_cur.strobe_busy = 1'b1;
                    end
                end
                sfa_pkg::SFA_ST_WAIT: begin
                    if (ack_arrived) begin
                        next_cur.ack_seen     = ack_sync;
                        next_cur.align_offset = link_phase;
                        if (offset_moved) begin
                            set_realigned = 1'b1;
                        end
                        next_cur.st          = sfa_pkg::SFA_ST_IDLE;
                        next_cur.strobe_busy = 1'b0;
                    end
                end
            endcase

            // reference edges: expected at read phase zero
            if (sref_edge) begin
                if (edge_misaligned) begin
                    set_misalign = 1'b1;
                end
                if (edge_realigns) begin
                    next_cur.read_phase = PHASE_W'(1);
                    next_cur.synced     = 1'b1;
                    if (edge_misaligned) begin
                        set_realigned = 1'b1;
                    end
                end
                next_cur.lat_cnt = '0;
                next_cur.lat_run = 1'b1;
            end else if (cur.lat_run) begin
                if (i_first_sample) begin
                    next_cur.lat_run = 1'b0;
                    next_cur.lat_val = lat_est;
                end else if (!lat_held) begin
                    next_cur.lat_cnt = lat_arrive;
                end
            end

            // datapath disable re-arms strobe alignment
            if (dp_rearm) begin
                next_cur.synced = 1'b0;
            end

            // sticky alarms, a new event wins over a clear
            if (set_realigned) begin
                next_cur.realigned_alarm = 1'b1;
            end else if (i_clr_realigned) begin
                next_cur.realigned_alarm = 1'b0;
            end
            if (set_misalign) begin
                next_cur.misalign_alarm = 1'b1;
            end else if (i_clr_misalign) begin
                next_cur.misalign_alarm = 1'b0;
            end

            // registered read data
            if (rd_align) begin
                next_cur.rdata = align_word;
            end else if (rd_lat3) begin
                next_cur.rdata = lat3_word;
            end else if (i_rd) begin
                next_cur.rdata = `SFA_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur.st                   <= sfa_pkg::SFA_ST_IDLE;
            cur.strobe_busy          <= 1'b0;
            cur.refedge_align_enable <= 1'(`SFA_ALIGN_RESET >> `SFA_REFEDGE_EN_BIT);
            cur.strobe_bit           <= 1'(`SFA_ALIGN_RESET >> `SFA_STROBE_BIT);
            cur.align_rsv            <= ALIGN_RSV_W'(`SFA_ALIGN_RESET >> `SFA_ALIGN_RSV_LSB);
            cur.req_tgl              <= 1'b0;
            cur.ack_seen             <= 1'b0;
            cur.sref_prev            <= 1'b0;
            cur.read_phase           <= '0;
            cur.align_offset         <= '0;
            cur.synced               <= 1'b0;
            cur.realigned_alarm      <= 1'b0;
            cur.misalign_alarm       <= 1'b0;
            cur.lat_cnt              <= '0;
            cur.lat_run              <= 1'b0;
            cur.lat_val              <= LAT_W'(`SFA_LAT_RESET);
            cur.rdata                <= 8'h00;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_rdata                = cur.rdata;
    assign o_realigned_alarm      = cur.realigned_alarm;
    assign o_misalign_alarm       = cur.misalign_alarm;
    assign o_refedge_align_enable = cur.refedge_align_enable;
    assign o_ref_synced           = cur.synced;
    assign o_strobe_busy          = cur.strobe_busy;
    assign o_read_phase           = cur.read_phase;
    assign o_align_offset         = cur.align_offset;

endmodule // sfa_align_top

`default_nettype wire

// *** src/sfa_defs.svh ***
`ifndef SFA_DEFS_SVH
`define SFA_DEFS_SVH

// register offsets
`define SFA_LAT3_OFS        12'h213
`define SFA_ALIGN_OFS       12'h220

// buffer_alignment_control fields
`define SFA_REFEDGE_EN_BIT  0
`define SFA_STROBE_BIT      1
`define SFA_ALIGN_RSV_LSB   2
`define SFA_ALIGN_RSV_MSB   7
`define SFA_ALIGN_RESET     8'h00

// fifo3_latency_readback fields
`define SFA_LAT_LSB         0
`define SFA_LAT_MSB         4
`define SFA_LAT_RSV_W       3
`define SFA_LAT_RESET       5'h00

// latency correction by interface mode
`define SFA_LAT_SUB_MODE0   5'h03
`define SFA_LAT_SUB_OTHER   5'h01

// value read at an unmapped offset
`define SFA_UNMAPPED_READ   8'h00

`endif

// *** src/sfa_pkg.sv ***
package sfa_pkg;

    // strobe alignment handshake states
    typedef enum logic [1:0] {
        SFA_ST_IDLE = 2'b01,
        SFA_ST_WAIT = 2'b10
    } sfa_state_t;

endpackage

// *** src/sfa_sync2.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfa_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sfa_sync_state_t;

    sfa_sync_state_t cur;
    sfa_sync_state_t next_cur;

    always_comb begin
        next_cur        = cur;
        next_cur.stage1 = i_async;
        next_cur.stage2 = cur.stage1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_sync = cur.stage2;

endmodule // sfa_sync2

`default_nettype wire

// *** src/sfa_link_capture.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfa_link_capture #(
    parameter int PHASE_W = 3
) (
    // link clock and reset
    input  wire logic               i_lvds_clk,
    input  wire logic               i_rst_n,
    // strobes of the two reference banks, on the link clock
    input  wire logic               i_strobe_bank0,
    input  wire logic               i_strobe_bank2,
    // from the converter domain
    input  wire logic               i_use_bank0,
    input  wire logic               i_req_tgl,
    // to the converter domain
    output var  logic               o_ack_tgl,
    output var  logic [PHASE_W-1:0] o_phase
);

    typedef struct packed {
        logic [1:0][PHASE_W-1:0] rx_phase;
        logic                    req_seen;
        logic                    ack_tgl;
        logic [PHASE_W-1:0]      hold;
    } sfa_link_state_t;

    sfa_link_state_t cur;
    sfa_link_state_t next_cur;
    logic [1:0]      strobe;
    logic [1:0]      ctl_sync;

    assign strobe = {i_strobe_bank2, i_strobe_bank0};

    sfa_sync2 #(
        .WIDTH (2)
    ) u_ctl_sync (
        .i_clk   (i_lvds_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_req_tgl, i_use_bank0}),
        .o_sync  (ctl_sync)
    );

    always_comb begin
        next_cur = cur;
        // receiver alignment: each bank restarts its phase on its strobe
        for (int b = 0; b < 2; b++) begin
            if (strobe[b]) begin
                next_cur.rx_phase[b] = '0;
            end else begin
                next_cur.rx_phase[b] = PHASE_W'(cur.rx_phase[b] + 1'b1);
            end
        end
        // take the present phase at once, no wait for a strobe
        if (ctl_sync[1] != cur.req_seen) begin
            next_cur.req_seen = ctl_sync[1];
            next_cur.hold     = ctl_sync[0] ? cur.rx_phase[0] : cur.rx_phase[1];
            next_cur.ack_tgl  = ~cur.ack_tgl;
        end
    end

    always_ff @(posedge i_lvds_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_ack_tgl = cur.ack_tgl;
    assign o_phase   = cur.hold;

endmodule // sfa_link_capture

`default_nettype wire

// *** dv/sfa_align_top_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none

`include "sfa_defs.svh"

module sfa_align_top_asserts #(
    parameter int PHASE_W = 3
) (
    // converter clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    // register port
    input  wire logic               i_ce,
    input  wire logic [11:0]        i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    input  wire logic [7:0]         o_rdata,
    // alarm clears
    input  wire logic               i_clr_realigned,
    input  wire logic               i_clr_misalign,
    // status
    input  wire logic               o_realigned_alarm,
    input  wire logic               o_misalign_alarm,
    input  wire logic               o_refedge_align_enable,
    input  wire logic               o_ref_synced,
    input  wire logic               o_strobe_busy,
    input  wire logic [PHASE_W-1:0] o_align_offset
);
    logic bit1_q;
    wire  logic wr_al = i_ce && i_wr && (i_addr == `SFA_ALIGN_OFS);

    // shadow of the stored strobe bit, to spot a zero-to-one write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) bit1_q <= 1'b0;
        else if (wr_al) bit1_q <= i_wdata[`SFA_STROBE_BIT];
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_strobe_start: assert property (wr_al && i_wdata[1] && !bit1_q && !o_ref_synced
        && !o_strobe_busy |=> o_strobe_busy) else $error("strobe write did not start");
    a_strobe_done: assert property ($rose(o_strobe_busy) |-> ##[1:40] !o_strobe_busy)
        else $error("strobe alignment did not complete");
    a_no_self_align: assert property ($changed(o_align_offset) |-> $past(o_strobe_busy))
        else $error("offset changed without request");
    a_realign_flag: assert property ($fell(o_strobe_busy) && $changed(o_align_offset)
        |-> ##[0:1] o_realigned_alarm) else $error("changed offset without alarm");
    a_synced_ignore: assert property (wr_al && i_wdata[1] && o_ref_synced
        && !o_strobe_busy |=> !o_strobe_busy) else $error("strobe taken after sync");
    a_enable_bit: assert property (wr_al |=> o_refedge_align_enable == $past(i_wdata[0]))
        else $error("enable bit not stored");
    a_sync_enabled: assert property ($rose(o_ref_synced)
        |-> o_refedge_align_enable || $past(o_refedge_align_enable))
        else $error("synced while disabled");
    a_realigned_sticky: assert property (o_realigned_alarm && !i_clr_realigned
        |=> o_realigned_alarm) else $error("realigned alarm dropped");
    a_misalign_sticky: assert property (o_misalign_alarm && !i_clr_misalign
        |=> o_misalign_alarm) else $error("misalign alarm dropped");
    a_lat_rsv: assert property (i_ce && i_rd && i_addr == `SFA_LAT3_OFS
        |=> o_rdata[7:5] == 3'h0) else $error("latency reserved bits set");

    c_strobe: cover property ($fell(o_strobe_busy));
    c_misalign: cover property ($rose(o_misalign_alarm));
    c_synced: cover property ($rose(o_ref_synced));
endmodule // sfa_align_top_asserts

bind sfa_align_top sfa_align_top_asserts #(.PHASE_W(PHASE_W)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_clr_realigned(i_clr_realigned),
    .i_clr_misalign(i_clr_misalign), .o_realigned_alarm(o_realigned_alarm),
    .o_misalign_alarm(o_misalign_alarm), .o_refedge_align_enable(o_refedge_align_enable),
    .o_ref_synced(o_ref_synced), .o_strobe_busy(o_strobe_busy),
    .o_align_offset(o_align_offset));

`default_nettype wire

// *** dv/sfa_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module sfa_src_model (
    // link run control and strobe levels
    input  wire logic i_run,
    input  wire logic i_hold0,
    input  wire logic i_hold2,
    // link clock and strobes
    output wire logic o_lvds_clk,
    output var  logic o_strobe_bank0,
    output var  logic o_strobe_bank2
);
    logic clk_q = 1'b0;

    assign o_lvds_clk = clk_q;

    // 125 ns link clock, parked low when the link is idle
    always begin
        #63;
        if (i_run || clk_q) clk_q = ~clk_q;
        #62;
        if (i_run || clk_q) clk_q = ~clk_q;
    end

    // strobes launched on the falling link edge so the receiver aligns first
    initial begin
        o_strobe_bank0 = 1'b0;
        o_strobe_bank2 = 1'b0;
        forever begin
            @(negedge clk_q);
            o_strobe_bank0 <= i_hold0;
            o_strobe_bank2 <= i_hold2;
        end
    end
endmodule // sfa_src_model

`default_nettype wire

// *** dv/sfa_align_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

`include "sfa_defs.svh"

module sfa_align_top_tb;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, clr_re = 0, clr_mis = 0, datapath_enable = 1;
    logic bank0 = 1, first = 0, sysref = 0, run = 1, hold0 = 1, hold2 = 0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [1:0]  mode = 2'h0;
    logic        lclk, stb0, stb2, re_alm, mis_alm, en, synced, busy;
    logic [2:0]  rph, aoff;
    int          mismatches = 0, checks_done = 0;

    always #50 clk = ~clk;

    sfa_src_model u_src (.i_run(run), .i_hold0(hold0), .i_hold2(hold2), .o_lvds_clk(lclk),
        .o_strobe_bank0(stb0), .o_strobe_bank2(stb2));

    sfa_align_top u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_clr_realigned(clr_re),
        .i_clr_misalign(clr_mis), .i_datapath_enable(datapath_enable), .i_interface_mode(mode),
        .i_bank0_in_use(bank0), .i_first_sample(first), .i_sysref(sysref),
        .i_lvds_clk(lclk), .i_strobe_bank0(stb0), .i_strobe_bank2(stb2),
        .o_realigned_alarm(re_alm), .o_misalign_alarm(mis_alm),
        .o_refedge_align_enable(en), .o_ref_synced(synced), .o_strobe_busy(busy),
        .o_read_phase(rph), .o_align_offset(aoff));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk) wr = 0;
        @(negedge clk);
    endtask

    task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
        addr = a;
        rd = 1;
        @(negedge clk) rd = 0;
        @(negedge clk);
        chk(rdata, e);
    endtask

    // clear then set the strobe bit, check busy, then wait up to 60 clocks for busy to drop
    task automatic strobe_align(input logic exp_busy);
        int n;
        wr_reg(`SFA_ALIGN_OFS, 8'h00);
        wr_reg(`SFA_ALIGN_OFS, 8'h02);
        chk({7'h0, busy}, {7'h0, exp_busy});
        for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge clk);
        chk({7'h0, busy}, 8'h00);
    endtask

    task automatic ref_edge(input int gap);
        sysref = 1;
        repeat (2) @(negedge clk);
        sysref = 0;
        repeat (gap - 2) @(negedge clk);
    endtask

    task automatic clear_alarms();
        clr_re = 1;
        clr_mis = 1;
        @(negedge clk) {clr_re, clr_mis} = 2'b00;
        @(negedge clk);
    endtask

    initial begin
        #1000000;
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        repeat (2) @(negedge clk);
        rd_reg(`SFA_LAT3_OFS, 8'h00);
        rd_reg(`SFA_ALIGN_OFS, 8'h00);
        rd_reg(12'h214, 8'h00);
        wr_reg(`SFA_ALIGN_OFS, 8'hfc);
        rd_reg(`SFA_ALIGN_OFS, 8'hfc);
        wr_reg(`SFA_LAT3_OFS, 8'hff);
        rd_reg(`SFA_LAT3_OFS, 8'h00);
        // bank 0 held at phase zero and in use
        repeat (10) @(negedge clk);
        strobe_align(1'b1);
        chk({5'h0, aoff}, 8'h00);
        chk({6'h0, re_alm, mis_alm}, 8'h00);
        {bank0, hold0, hold2} = 3'b001;
        repeat (10) @(negedge clk);
        strobe_align(1'b1);
        chk({5'h0, aoff}, 8'h00);
        hold2 = 0;
        repeat (7) @(negedge clk);
        strobe_align(1'b1);
        chk({7'h0, re_alm}, {7'h0, aoff !== 3'h0});
        repeat (20) @(negedge clk);
        run = 0;
        clear_alarms();
        // first sample ten clocks after the reference edge, modes 0 to 2
        for (int m = 0; m < 3; m++) begin
            mode = m[1:0];
            ref_edge(12);
            first = 1;
            @(negedge clk) first = 0;
            @(negedge clk);
            rd_reg(`SFA_LAT3_OFS, (m == 0) ? 8'h07 : 8'h09);
        end
        wr_reg(`SFA_ALIGN_OFS, 8'h01);
        ref_edge(6);
        clear_alarms();
        ref_edge(8);
        chk({4'h0, en, synced, re_alm, mis_alm}, 8'h0c);
        repeat (3) @(negedge clk);
        ref_edge(6);
        chk({6'h0, re_alm, mis_alm}, 8'h03);
        wr_reg(`SFA_ALIGN_OFS, 8'h00);
        clear_alarms();
        ref_edge(6);
        chk({6'h0, re_alm, mis_alm}, 8'h01);
        chk({7'h0, synced}, 8'h01);
        chk({5'h0, rph}, 8'h06);
        run = 1;
        strobe_align(1'b0);
        datapath_enable = 0;
        @(negedge clk) datapath_enable = 1;
        @(negedge clk);
        chk({7'h0, synced}, 8'h00);
        strobe_align(1'b1);
        end_of_test();
    end
endmodule // sfa_align_top_tb

`default_nettype wire
